//--- src/sysbus_pkg.sv
package sysbus_pkg;
  // ==========================================================
  // bus widths
  localparam int CMD_W = 5;
  localparam int AD_W = 32;
  localparam int FIFO_DEPTH = 8;
  // ==========================================================
  // command encodings: bit 4 set marks a data identifier
  localparam logic [4:0] CMD_READ = 5'h00;
  localparam logic [4:0] CMD_WRITE = 5'h08;
  localparam logic [4:0] CMD_DATA_FLAG = 5'h10;
  localparam logic [4:0] CMD_LAST_FLAG = 5'h08;
  localparam logic [4:0] CMD_ERR_FLAG = 5'h04;
  localparam logic [4:0] MIDDLE_WORD_TAG = 5'h10;
  localparam logic [4:0] FINAL_WORD_TAG = 5'h18;
  // ==========================================================
  // timing
  localparam int RETAKE_CYCLES = 2;
  localparam logic [1:0] RETAKE_CNT = 2'h2;
  typedef enum logic [2:0] {
    ST_MASTER,
    ST_READ_WAIT,
    ST_AGENT_OWN,
    ST_RETAKE
  } arb_state_t;
endpackage : sysbus_pkg

//--- src/word_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : word_fifo
`default_nettype wire

//--- src/sysbus_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - agent requests may start at any time, master included; immediate if slave.
// - after a read request goes out, drop ownership until response.
// - with agent request idle, stay slave until response, then retake.
// - agent request held at final response word keeps agent owner.
// - agent asserts request; it owns the bus once we drop owner.
// - retake ownership exactly two cycles after agent drops request.
// - when granting, drop owner and float command and address/data.
// - agent returns read data; agent-issued commands are always served (the code decodes only CMD_WRITE, when not master).
// - we may raise our own bus request; agent yields by priority.
// - warm or cold reset leaves us master and the agent slave.
// - external write only raises an interrupt request, nothing else.
// - full response then release; retake two cycles after last word.
// - any error-tagged response word raises a bus error.
// - request held at final word chains a write; retake two later.
// - an inserted external write keeps us slave until read data.
// - data identifiers distinguish middle words from the final word.
module sysbus_arbiter
  import sysbus_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic POWER_ON_RESET_N,
  input wire logic AGENT_BUS_REQUEST_N,
  input wire logic AGENT_CYCLE_VALID_N,
  output logic CPU_BUS_OWNER_N,
  output logic CPU_BUS_REQUEST_N,
  output logic CPU_CYCLE_VALID_N,
  input wire logic [sysbus_pkg::CMD_W-1:0] CMD_TAG_BUS_I,
  output logic [sysbus_pkg::CMD_W-1:0] CMD_TAG_BUS_O,
  output logic CMD_TAG_BUS_OE,
  input wire logic [sysbus_pkg::AD_W-1:0] ADDR_DATA_BUS_I,
  output logic [sysbus_pkg::AD_W-1:0] ADDR_DATA_BUS_O,
  output logic ADDR_DATA_BUS_OE,
  input wire logic RD_REQ_VALID,
  output logic RD_REQ_READY,
  input wire logic [sysbus_pkg::AD_W-1:0] RD_REQ_ADDR,
  input wire logic WANT_BUS,
  output logic RD_DATA_VALID,
  input wire logic RD_DATA_READY,
  output logic [sysbus_pkg::AD_W-1:0] RD_DATA,
  output logic RD_DONE,
  output logic BUS_ERROR,
  output logic EXT_INTR,
  output logic [sysbus_pkg::AD_W-1:0] EXT_INTR_DATA
);
  import sysbus_pkg::*;

  // ==========================================================
  // input synchronisers (two stages, first read only by second)
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [CMD_W-1:0] cmd1_q;
  logic [CMD_W-1:0] cmd2_q;
  logic [AD_W-1:0] ad1_q;
  logic [AD_W-1:0] ad2_q;
  logic por1_q;
  logic por2_q;
  logic agent_bus_request_n;
  logic agent_cycle_valid_n;
  logic [CMD_W-1:0] cmd_in;
  logic [AD_W-1:0] ad_in;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      cmd1_q <= '0;
      cmd2_q <= '0;
      ad1_q <= '0;
      ad2_q <= '0;
      // idle level of the cold reset pin, so warm reset is not stretched
      por1_q <= 1'b1;
      por2_q <= 1'b1;
    end else begin
      s1_q <= {AGENT_BUS_REQUEST_N, AGENT_CYCLE_VALID_N, 1'b1};
      s2_q <= s1_q;
      cmd1_q <= CMD_TAG_BUS_I;
      cmd2_q <= cmd1_q;
      ad1_q <= ADDR_DATA_BUS_I;
      ad2_q <= ad1_q;
      por1_q <= POWER_ON_RESET_N;
      por2_q <= por1_q;
    end
  end
  assign agent_bus_request_n = !s2_q[2];
  assign agent_cycle_valid_n = !s2_q[1];
  assign cmd_in = cmd2_q;
  assign ad_in = ad2_q;

  function automatic logic is_data(input logic [CMD_W-1:0] c);
    is_data = (c & CMD_DATA_FLAG) != '0;
  endfunction : is_data
  function automatic logic is_last(input logic [CMD_W-1:0] c);
    is_last = is_data(c) && ((c & CMD_LAST_FLAG) != '0);
  endfunction : is_last

  // ==========================================================
  // ownership state machine
  arb_state_t state_q;
  logic pend_q;
  logic [1:0] cnt_q;
  logic issue_q;
  logic cold_q;
  logic take;
  logic wcmd_q;
  logic resp_word;
  logic resp_last;
  logic fifo_ready;

  // warm reset is RST; cold reset is the synchronised pin
  assign cold_q = !por2_q;
  // the data word of an inserted write is not part of the response
  assign resp_word = agent_cycle_valid_n && is_data(cmd_in) && pend_q
                     && !wcmd_q;
  assign resp_last = resp_word && is_last(cmd_in);
  // refused during cold reset, which would drop an accepted request
  assign RD_REQ_READY = (state_q == ST_MASTER) && !pend_q && !agent_bus_request_n
                        && !cold_q;
  assign take = RD_REQ_VALID && RD_REQ_READY;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_MASTER;
      pend_q <= 1'b0;
      cnt_q <= '0;
      issue_q <= 1'b0;
    end else if (cold_q) begin
      state_q <= ST_MASTER;
      pend_q <= 1'b0;
      cnt_q <= '0;
      issue_q <= 1'b0;
    end else begin
      issue_q <= 1'b0;
      case (state_q)
        ST_MASTER: begin
          if (agent_bus_request_n) begin
            state_q <= ST_AGENT_OWN;
          end else if (take) begin
            issue_q <= 1'b1;
            pend_q <= 1'b1;
            state_q <= ST_READ_WAIT;
          end
        end
        ST_READ_WAIT: begin
          // an inserted write is served here without leaving slave
          if (resp_last) begin
            pend_q <= 1'b0;
            cnt_q <= RETAKE_CNT - 2'h1;
            // request held at final word keeps agent owner
            state_q <= agent_bus_request_n ? ST_AGENT_OWN : ST_RETAKE;
          end
        end
        ST_AGENT_OWN: begin
          if (!agent_bus_request_n && !pend_q) begin
            cnt_q <= RETAKE_CNT - 2'h1;
            state_q <= ST_RETAKE;
          end else if (!agent_bus_request_n && pend_q) begin
            state_q <= ST_READ_WAIT;
          end else if (resp_last) begin
            pend_q <= 1'b0;
          end
        end
        ST_RETAKE: begin
          if (agent_bus_request_n) begin
            state_q <= ST_AGENT_OWN;
          end else if (cnt_q == '0) begin
            state_q <= ST_MASTER;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        default: begin
          state_q <= ST_MASTER;
        end
      endcase
    end
  end

  // ==========================================================
  // bus drive: only the issue cycle drives; owner drops after it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CPU_BUS_OWNER_N <= 1'b0;
      CMD_TAG_BUS_O <= '0;
      ADDR_DATA_BUS_O <= '0;
      CMD_TAG_BUS_OE <= 1'b0;
      ADDR_DATA_BUS_OE <= 1'b0;
      CPU_CYCLE_VALID_N <= 1'b1;
    end else begin
      CPU_BUS_OWNER_N <= !(state_q == ST_MASTER && !agent_bus_request_n) || issue_q;
      CMD_TAG_BUS_OE <= take;
      ADDR_DATA_BUS_OE <= take;
      CMD_TAG_BUS_O <= CMD_READ;
      ADDR_DATA_BUS_O <= RD_REQ_ADDR;
      // releasing with the owner drop keeps us off the agent's lines
      CPU_CYCLE_VALID_N <= !take;
    end
  end

  // own bus request while the agent holds the bus and we have work
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CPU_BUS_REQUEST_N <= 1'b1;
    end else begin
      CPU_BUS_REQUEST_N <= !(state_q == ST_AGENT_OWN && WANT_BUS);
    end
  end

  // ==========================================================
  // response path: words into the fifo, error flag sticky per burst
  logic err_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      err_q <= 1'b0;
      BUS_ERROR <= 1'b0;
      RD_DONE <= 1'b0;
    end else begin
      BUS_ERROR <= 1'b0;
      RD_DONE <= resp_last;
      if (resp_last) begin
        err_q <= 1'b0;
        BUS_ERROR <= err_q || ((cmd_in & CMD_ERR_FLAG) != '0);
      end else if (resp_word) begin
        err_q <= err_q || ((cmd_in & CMD_ERR_FLAG) != '0);
      end
    end
  end

  word_fifo #(.WIDTH(AD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(resp_word),
    .in_ready(fifo_ready),
    .in_data(ad_in),
    .out_valid(RD_DATA_VALID),
    .out_ready(RD_DATA_READY),
    .out_data(RD_DATA)
  );

  // ==========================================================
  // external write: command cycle then final-tagged data cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wcmd_q <= 1'b0;
      EXT_INTR <= 1'b0;
      EXT_INTR_DATA <= '0;
    end else begin
      EXT_INTR <= 1'b0;
      wcmd_q <= agent_cycle_valid_n && !is_data(cmd_in) && (cmd_in == CMD_WRITE)
                && (state_q != ST_MASTER);
      if (wcmd_q && agent_cycle_valid_n && is_last(cmd_in)) begin
        EXT_INTR <= 1'b1;
        EXT_INTR_DATA <= ad_in;
      end
    end
  end
endmodule : sysbus_arbiter
`default_nettype wire

//--- sim/sysbus_arbiter_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sysbus_arbiter_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic POWER_ON_RESET_N,
  input wire logic AGENT_BUS_REQUEST_N,
  input wire logic CPU_BUS_OWNER_N,
  input wire logic CPU_BUS_REQUEST_N,
  input wire logic CPU_CYCLE_VALID_N,
  input wire logic CMD_TAG_BUS_OE,
  input wire logic ADDR_DATA_BUS_OE,
  input wire logic RD_REQ_VALID,
  input wire logic RD_REQ_READY,
  input wire logic WANT_BUS,
  input wire logic RD_DONE,
  input wire logic BUS_ERROR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic wait_q;
  logic [2:0] hi_q;
  // cold reset drops the pending read, so the tracker follows it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wait_q <= 1'b0;
    end else if (!POWER_ON_RESET_N || RD_DONE) begin
      wait_q <= 1'b0;
    end else if (!CPU_CYCLE_VALID_N) begin
      wait_q <= 1'b1;
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hi_q <= 3'h0;
    end else if (!AGENT_BUS_REQUEST_N) begin
      hi_q <= 3'h0;
    end else if (hi_q != 3'h7) begin
      hi_q <= hi_q + 3'h1;
    end
  end
  // ==========================================================
  // read issue
  sequence issue_s;
    !CPU_CYCLE_VALID_N && CMD_TAG_BUS_OE && ADDR_DATA_BUS_OE;
  endsequence
  sequence release_s;
    CPU_BUS_OWNER_N && !CMD_TAG_BUS_OE && !ADDR_DATA_BUS_OE;
  endsequence
  reset_master_a: assert property (
    $fell(RST) |-> !CPU_BUS_OWNER_N && !CMD_TAG_BUS_OE)
    else $error("not master after reset");
  read_issue_a: assert property (
    RD_REQ_VALID && RD_REQ_READY |=> issue_s ##1 release_s)
    else $error("read issue or release wrong");
  drive_owner_a: assert property (
    CMD_TAG_BUS_OE || ADDR_DATA_BUS_OE |-> !CPU_BUS_OWNER_N)
    else $error("drives bus while slave");
  pend_slave_a: assert property (
    wait_q |-> CPU_BUS_OWNER_N)
    else $error("retook bus with read pending");
  retake_gap_a: assert property (
    $fell(CPU_BUS_OWNER_N) |-> hi_q >= 3'h3)
    else $error("retook bus too early");
  req_retake_a: assert property (
    $rose(AGENT_BUS_REQUEST_N) && !wait_q |-> ##[2:6] !CPU_BUS_OWNER_N)
    else $error("bus not retaken");
  done_retake_a: assert property (
    RD_DONE && hi_q >= 3'h4 |-> ##[1:4] !CPU_BUS_OWNER_N)
    else $error("no retake after response");
  chain_hold_a: assert property (
    RD_DONE && !AGENT_BUS_REQUEST_N |=> CPU_BUS_OWNER_N [*2])
    else $error("retook bus from chaining agent");
  err_done_a: assert property (
    BUS_ERROR |-> RD_DONE)
    else $error("bus error outside response end");
  cpu_req_a: assert property (
    !CPU_BUS_REQUEST_N |-> $past(WANT_BUS))
    else $error("bus request without cause");
endmodule : sysbus_arbiter_properties
`default_nettype wire

//--- sim/agent_model.sv
`timescale 1ns/100ps
`default_nettype none
module agent_model (
  input wire logic clk,
  input wire logic owner_n,
  input wire logic cmd_oe,
  input wire logic [sysbus_pkg::CMD_W-1:0] cmd_o,
  input wire logic ad_oe,
  input wire logic [sysbus_pkg::AD_W-1:0] ad_o,
  output logic req_n,
  output logic valid_n,
  output logic [sysbus_pkg::CMD_W-1:0] cmd_i,
  output logic [sysbus_pkg::AD_W-1:0] ad_i
);
  import sysbus_pkg::*;
  logic drv = 1'b0;
  logic [CMD_W-1:0] cq = '0;
  logic [AD_W-1:0] aq = '0;
  initial req_n = 1'b1;
  initial valid_n = 1'b1;
  // a released line shows the inverse, so stale data cannot pass
  assign cmd_i = cmd_oe ? cmd_o : (drv ? cq : ~cq);
  assign ad_i = ad_oe ? ad_o : (drv ? aq : ~aq);
  task automatic beat(input logic d, input logic [CMD_W-1:0] c,
      input logic [AD_W-1:0] a, input logic v);
    drv = d;
    cq = c;
    aq = a;
    valid_n = ~v;
    @(posedge clk);
    #10;
  endtask : beat
  task automatic grab(input logic ask);
    int n;
    n = 0;
    if (ask) req_n = 1'b0;
    while (owner_n !== 1'b1 && n < 60) begin
      beat(1'b0, cq, aq, 1'b0);
      n++;
    end
    beat(1'b0, cq, aq, 1'b0);
  endtask : grab
  task automatic ext_write(input logic [AD_W-1:0] a,
      input logic [AD_W-1:0] d, input int hold);
    grab(1'b1);
    repeat (hold) beat(1'b0, cq, aq, 1'b0);
    beat(1'b1, CMD_WRITE, a, 1'b1);
    req_n = 1'b1;
    beat(1'b1, FINAL_WORD_TAG, d, 1'b1);
    beat(1'b0, cq, aq, 1'b0);
  endtask : ext_write
  task automatic respond(input int n, input int bad, input logic chain,
      input logic slow, input logic [AD_W-1:0] base);
    logic [CMD_W-1:0] t;
    grab(1'b0);
    for (int i = 0; i < n; i++) begin
      t = (i == n - 1) ? FINAL_WORD_TAG : MIDDLE_WORD_TAG;
      if (i == bad) t = t | CMD_ERR_FLAG;
      if (chain && i == n - 1) req_n = 1'b0;
      beat(1'b1, t, base + AD_W'(i), 1'b1);
      if (slow) beat(1'b1, t, base + AD_W'(i), 1'b0);
    end
    if (!chain) beat(1'b0, cq, aq, 1'b0);
  endtask : respond
endmodule : agent_model
`default_nettype wire

//--- sim/sysbus_arbiter_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  fail_count++; $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module sysbus_arbiter_bench;
  import sysbus_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por_n = 1'b1;
  logic req_v = 1'b0;
  logic want = 1'b0;
  logic dready = 1'b0;
  logic [AD_W-1:0] raddr = '0;
  logic areq_n, aval_n, own_n, creq_n, cval_n, coe, aoe, rready;
  logic dval, done, berr, intr;
  logic [CMD_W-1:0] ci, co;
  logic [AD_W-1:0] ai, ao, rdata, idata;
  int fail_count = 0;
  int samples_checked = 0;
  int dones = 0;
  int errs = 0;
  int intrs = 0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    dones <= dones + int'(done === 1'b1);
    errs <= errs + int'(berr === 1'b1);
    intrs <= intrs + int'(intr === 1'b1);
  end
  sysbus_arbiter uut (.CLK(clk), .RST(rst), .POWER_ON_RESET_N(por_n),
    .AGENT_BUS_REQUEST_N(areq_n), .AGENT_CYCLE_VALID_N(aval_n),
    .CPU_BUS_OWNER_N(own_n), .CPU_BUS_REQUEST_N(creq_n),
    .CPU_CYCLE_VALID_N(cval_n), .CMD_TAG_BUS_I(ci), .CMD_TAG_BUS_O(co),
    .CMD_TAG_BUS_OE(coe), .ADDR_DATA_BUS_I(ai), .ADDR_DATA_BUS_O(ao),
    .ADDR_DATA_BUS_OE(aoe), .RD_REQ_VALID(req_v), .RD_REQ_READY(rready),
    .RD_REQ_ADDR(raddr), .WANT_BUS(want), .RD_DATA_VALID(dval),
    .RD_DATA_READY(dready), .RD_DATA(rdata), .RD_DONE(done),
    .BUS_ERROR(berr), .EXT_INTR(intr), .EXT_INTR_DATA(idata));
  agent_model agent (.clk(clk), .owner_n(own_n), .cmd_oe(coe),
    .cmd_o(co), .ad_oe(aoe), .ad_o(ao), .req_n(areq_n),
    .valid_n(aval_n), .cmd_i(ci), .ad_i(ai));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick
  task automatic rd_issue(input logic [AD_W-1:0] a);
    int n;
    n = 0;
    req_v = 1'b1;
    raddr = a;
    while (rready !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    tick(1);
    req_v = 1'b0;
    `CHK({cval_n, coe, co, ao}, {2'b01, CMD_READ, a})
    tick(1);
    `CHK({own_n, coe, aoe, rready}, 4'h8)
  endtask : rd_issue
  task automatic drain(input int n, input logic [AD_W-1:0] base);
    int k;
    dready = 1'b1;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (dval !== 1'b1 && k < 50) begin
        tick(1);
        k++;
      end
      `CHK(rdata, base + AD_W'(i))
      tick(1);
    end
    dready = 1'b0;
    `CHK(dval, 1'b0)
  endtask : drain
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
  initial begin
    tick(5);
    rst = 1'b0;
    tick(1);
    `CHK({own_n, creq_n, cval_n, coe, aoe}, 5'h0c)
    // eight words with the consumer stalled fill the buffer
    rd_issue(32'h0000_1000);
    agent.respond(8, 8, 1'b0, 1'b1, 32'h0000_a000);
    tick(8);
    `CHK({dones, errs}, {32'd1, 32'd0})
    `CHK(own_n, 1'b0)
    drain(8, 32'h0000_a000);
    // error word, then a write chained after the final word
    rd_issue(32'h0000_2000);
    agent.respond(2, 0, 1'b1, 1'b0, 32'h0000_b000);
    agent.ext_write(32'h0000_0040, 32'h0000_5a5a, 1);
    tick(8);
    `CHK({dones, errs, intrs}, {32'd2, 32'd1, 32'd1})
    `CHK(idata, 32'h0000_5a5a)
    `CHK(own_n, 1'b0)
    drain(2, 32'h0000_b000);
    want = 1'b1;
    fork
      agent.ext_write(32'h0000_0080, 32'h0000_00c3, 4);
      begin
        tick(9);
        `CHK({creq_n, coe, own_n}, 3'h1)
      end
    join
    tick(8);
    `CHK({intrs, idata}, {32'd2, 32'h0000_00c3})
    `CHK({own_n, creq_n}, 2'h1)
    want = 1'b0;
    rd_issue(32'h0000_3000);
    por_n = 1'b0;
    tick(5);
    `CHK(own_n, 1'b0)
    por_n = 1'b1;
    tick(4);
    end_sim();
  end
endmodule : sysbus_arbiter_bench
bind sysbus_arbiter sysbus_arbiter_properties chk (.CLK, .RST,
  .POWER_ON_RESET_N, .AGENT_BUS_REQUEST_N, .CPU_BUS_OWNER_N,
  .CPU_BUS_REQUEST_N, .CPU_CYCLE_VALID_N, .CMD_TAG_BUS_OE,
  .ADDR_DATA_BUS_OE, .RD_REQ_VALID, .RD_REQ_READY, .WANT_BUS,
  .RD_DONE, .BUS_ERROR);
`default_nettype wire
